// >>> framer_model.sv
`timescale 1ns/10ps
module framer_model #(
  parameter realtime PH = 0
) (
  input  wire logic       run,
  input  wire logic [1:0] pat,
  output logic      [2:0] ck,
  output logic      [2:0] p,
  output logic      [2:0] n
);
  // Clock parks low between frames
  initial begin
    {ck, p, n} = 9'h000;
    #PH;
    forever begin
      #62.5;
      if (run || ck[0]) begin
        ck = ~ck;
        // Rails launched on rise, held over fall
        if (ck[0]) {p, n} = {{3{pat[1]}}, {3{pat[0]}}};
      end
    end
  end
endmodule : framer_model

// >>> loopback_ctrl.sv
`timescale 1ns/10ps
`include "loopback_defines.svh"
module loopback_ctrl
  import loopback_pkg::*;
#(
  parameter int CHANNELS  = `CHANNELS,
  parameter int BUF_DEPTH = `BUF_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   hardware_mode,
  input  wire logic                   transmit_shutoff,
  input  wire logic [CHANNELS-1:0]    local_loop_select,
  input  wire logic [CHANNELS-1:0]    remote_loop_select,
  input  wire logic [`ADDR_WIDTH-1:0] reg_addr,
  input  wire logic [`REG_WIDTH-1:0]  reg_wdata,
  input  wire logic                   reg_write,
  output logic      [`REG_WIDTH-1:0]  reg_rdata,
  input  wire logic [CHANNELS-1:0]    tx_clock_in,
  input  wire logic [CHANNELS-1:0]    tx_pos_rail_in,
  input  wire logic [CHANNELS-1:0]    tx_neg_rail_in,
  output logic      [CHANNELS-1:0]    tx_line_pos,
  output logic      [CHANNELS-1:0]    tx_line_neg,
  output logic      [CHANNELS-1:0]    tx_line_oe_n,
  input  wire logic [CHANNELS-1:0]    rx_line_clock,
  input  wire logic [CHANNELS-1:0]    rx_line_pos,
  input  wire logic [CHANNELS-1:0]    rx_line_neg,
  output logic      [CHANNELS-1:0]    rx_pos_rail_out,
  output logic      [CHANNELS-1:0]    rx_neg_rail_out,
  output logic      [CHANNELS-1:0]    rx_recovered_clock,
  input  wire logic [CHANNELS-1:0]    rx_stall,
  output logic      [CHANNELS-1:0]    rx_ready
);

  top_s top;
  top_s next_top;
  logic hw;

  logic [CHANNELS-1:0][`REG_WIDTH-1:0] tx_ctrl_q;
  logic [CHANNELS-1:0][`REG_WIDTH-1:0] loop_cfg_q;

  assign hw = top.hw_sync[1];

  // Global strap synchroniser and register read-back
  always_comb begin
    next_top = top;
    next_top.hw_sync = {top.hw_sync[0], hardware_mode};
    next_top.read_data = `REG_RESET;
    for (int i = 0; i < CHANNELS; i++) begin
      if (reg_addr == 5'(i * `CHAN_STRIDE) + `TX_CTRL_OFS) begin
        next_top.read_data = tx_ctrl_q[i];
      end
      if (reg_addr == 5'(i * `CHAN_STRIDE) + `LOOP_CFG_OFS) begin
        next_top.read_data = loop_cfg_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      top <= '0;
    end else begin
      top <= next_top;
    end
  end

  assign reg_rdata = top.read_data;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : chan
      localparam logic [4:0] BASE = 5'(g * `CHAN_STRIDE);

      chan_s      c;
      chan_s      next_c;
      loop_mode_e mode;
      logic       local_sel;
      logic       remote_sel;
      logic       tx_rise;
      logic       tx_fall;
      logic       rx_rise;
      logic       rx_fall;
      logic       src_rise;
      logic       src_clk;
      logic       shut_bit;
      logic       tx_on;

      rail_buffer_if #(.WIDTH(2)) rbuf ();

      rail_buffer #(
        .WIDTH (2),
        .DEPTH (BUF_DEPTH)
      ) u_buf (
        .clk  (clk),
        .rstn (rstn),
        .bus  (rbuf.store)
      );

      assign tx_rise = c.tx_clock_in_sync[1] && !c.tx_clock_in_prev;
      assign tx_fall = !c.tx_clock_in_sync[1] && c.tx_clock_in_prev;
      assign rx_rise = c.rx_recovered_clock_sync[1] && !c.rx_recovered_clock_prev;
      assign rx_fall = !c.rx_recovered_clock_sync[1] && c.rx_recovered_clock_prev;

      // Loop selects from pins or register bits
      always_comb begin
        if (hw) begin
          local_sel  = c.llb_sync[1];
          remote_sel = c.rlb_sync[1];
        end else begin
          local_sel  = c.loop_cfg[`LOCAL_LOOP_BIT];
          remote_sel = c.loop_cfg[`REMOTE_LOOP_BIT];
        end
      end

      // Mode decode
      always_comb begin
        case ({local_sel, remote_sel})
          2'b10:   mode = MODE_ANALOG_LOCAL;  // [RQ3] [RQ4]
          2'b11:   mode = MODE_DIGITAL_LOCAL; // [RQ6] [RQ7]
          2'b01:   mode = MODE_REMOTE;        // [RQ9] [RQ10]
          default: mode = MODE_NORMAL;        // [RQ17]
        endcase
      end

      // Shut-off: pin wins in both modes, bit only in host mode
      assign shut_bit = !hw && c.tx_ctrl[`SHUTOFF_BIT];     // [RQ13]
      assign tx_on    = rstn && !transmit_shutoff && !shut_bit; // [RQ15]

      // Pin acts straight on the driver enable, no register delay
      assign tx_line_oe_n[g] = !tx_on; // [RQ11] [RQ12] [RQ14]
      assign tx_line_pos[g]  = c.tx_pos;
      assign tx_line_neg[g]  = c.tx_neg;

      // Receive output timing follows the looped source clock
      always_comb begin
        case (mode)
          MODE_ANALOG_LOCAL,
          MODE_DIGITAL_LOCAL: begin
            src_clk  = c.tx_clock_in_sync[1];
            src_rise = tx_rise;
          end
          default: begin
            src_clk  = c.rx_recovered_clock_sync[1];
            src_rise = rx_rise;
          end
        endcase
      end

      // Fill side of the receive buffer
      always_comb begin
        case (mode)
          MODE_ANALOG_LOCAL: begin
            rbuf.in_valid = tx_fall;                         // [RQ1]
            rbuf.in_data  = {c.txp_sync[1], c.txn_sync[1]};  // [RQ2]
          end
          MODE_DIGITAL_LOCAL: begin
            rbuf.in_valid = tx_fall;                         // [RQ5]
            rbuf.in_data  = {c.txp_sync[1], c.txn_sync[1]};  // [RQ5]
          end
          default: begin
            rbuf.in_valid = rx_fall;                         // [RQ17]
            rbuf.in_data  = {c.rxp_sync[1], c.rxn_sync[1]};  // [RQ8]
          end
        endcase
      end

      assign rbuf.out_ready = src_rise && !c.stall_sync[1];
      assign rx_ready[g]    = rbuf.in_ready;

      always_comb begin
        next_c = c;
        next_c.tx_clock_in_sync = {c.tx_clock_in_sync[0], tx_clock_in[g]};
        next_c.txp_sync   = {c.txp_sync[0], tx_pos_rail_in[g]};
        next_c.txn_sync   = {c.txn_sync[0], tx_neg_rail_in[g]};
        next_c.rx_recovered_clock_sync = {c.rx_recovered_clock_sync[0], rx_line_clock[g]};
        next_c.rxp_sync   = {c.rxp_sync[0], rx_line_pos[g]};
        next_c.rxn_sync   = {c.rxn_sync[0], rx_line_neg[g]};
        next_c.llb_sync   = {c.llb_sync[0], local_loop_select[g]};
        next_c.rlb_sync   = {c.rlb_sync[0], remote_loop_select[g]};
        next_c.stall_sync = {c.stall_sync[0], rx_stall[g]};
        next_c.tx_clock_in_prev = c.tx_clock_in_sync[1];
        next_c.rx_recovered_clock_prev = c.rx_recovered_clock_sync[1];

        // Register writes
        if (reg_write && reg_addr == BASE + `TX_CTRL_OFS) begin
          next_c.tx_ctrl = reg_wdata; // [RQ13]
        end
        if (reg_write && reg_addr == BASE + `LOOP_CFG_OFS) begin
          next_c.loop_cfg = reg_wdata; // [RQ3] [RQ6] [RQ9]
        end

        // Transmit line data
        if (!tx_on) begin
          next_c.tx_pos = 1'b0; // [RQ11]
          next_c.tx_neg = 1'b0; // [RQ11]
        end else if (mode == MODE_REMOTE) begin
          if (rx_fall) begin
            next_c.tx_pos = c.rxp_sync[1]; // [RQ8]
            next_c.tx_neg = c.rxn_sync[1]; // [RQ8]
          end
        end else if (tx_fall) begin
          next_c.tx_pos = c.txp_sync[1]; // [RQ2] [RQ17]
          next_c.tx_neg = c.txn_sync[1]; // [RQ2] [RQ17]
        end

        // Receive rail outputs
        next_c.rx_clk = src_clk;
        if (rbuf.out_valid && rbuf.out_ready) begin
          next_c.rx_pos = rbuf.out_data[1]; // [RQ2] [RQ5] [RQ8]
          next_c.rx_neg = rbuf.out_data[0]; // [RQ2] [RQ5] [RQ8]
        end
      end

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          c <= '0; // [RQ16]
        end else begin
          c <= next_c;
        end
      end

      assign tx_ctrl_q[g]          = c.tx_ctrl;
      assign loop_cfg_q[g]         = c.loop_cfg;
      assign rx_pos_rail_out[g]    = c.rx_pos;
      assign rx_neg_rail_out[g]    = c.rx_neg;
      assign rx_recovered_clock[g] = c.rx_clk;
    end
  endgenerate

endmodule : loopback_ctrl

// >>> loopback_ctrl_sva.sv
`timescale 1ns/10ps
module loopback_ctrl_sva #(
  parameter int CHANNELS = 3
) (
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic                hardware_mode,
  input wire logic                transmit_shutoff,
  input wire logic [4:0]          reg_addr,
  input wire logic [4:0]          reg_wdata,
  input wire logic                reg_write,
  input wire logic [4:0]          reg_rdata,
  input wire logic [CHANNELS-1:0] tx_line_pos,
  input wire logic [CHANNELS-1:0] tx_line_neg,
  input wire logic [CHANNELS-1:0] tx_line_oe_n,
  input wire logic [CHANNELS-1:0] rx_ready
);
  logic mp;
  assign mp = (reg_addr[2:0] == 3'h1 || reg_addr[2:0] == 3'h4)
              && reg_addr < 5'h18;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_pin_all_off: assert property (transmit_shutoff |-> &tx_line_oe_n)
    else $error("shut-off pin left a driver on");
  a_off_line_quiet: assert property (
    (tx_line_oe_n & $past(tx_line_oe_n) & (tx_line_pos | tx_line_neg)) == '0)
    else $error("tri-stated channel still carries data");
  a_reg_read_back: assert property (
    reg_write && reg_addr == 5'h09 ##1 $stable(reg_addr)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("written value not read back");
  a_unmapped_zero: assert property (!$past(mp) |-> reg_rdata == 5'h00)
    else $error("unmapped address read nonzero");
  a_reset_state: assert property (disable iff (1'b0)
    !rstn ##1 !rstn |-> &tx_line_oe_n && &rx_ready && reg_rdata == 5'h00)
    else $error("wrong state during reset");
  a_bit_turns_off: assert property (
    !hardware_mode [*3] ##0 (reg_write && reg_addr == 5'h09 && reg_wdata[4])
    |=> tx_line_oe_n[1])
    else $error("shut-off bit did not tri-state");
  a_bit_turns_on: assert property (
    !hardware_mode [*3] ##0 (reg_write && reg_addr == 5'h09 && !reg_wdata[4])
    ##1 !transmit_shutoff |-> !tx_line_oe_n[1])
    else $error("cleared bit left driver off");
  a_hw_pin_rules: assert property (
    hardware_mode [*3] |-> tx_line_oe_n == {CHANNELS{transmit_shutoff}})
    else $error("hardware mode drivers not following pin");
  c_shut_pin: cover property (transmit_shutoff);
  c_loop_write: cover property (reg_write && reg_addr == 5'h04);
  c_buffer_full: cover property (rx_ready == '0);
endmodule : loopback_ctrl_sva

bind loopback_ctrl loopback_ctrl_sva #(.CHANNELS(CHANNELS)) i_sva (
  .clk(clk), .rstn(rstn), .hardware_mode(hardware_mode),
  .transmit_shutoff(transmit_shutoff), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
  .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg),
  .tx_line_oe_n(tx_line_oe_n), .rx_ready(rx_ready));

// >>> loopback_defines.svh
`ifndef LOOPBACK_DEFINES_SVH
`define LOOPBACK_DEFINES_SVH
// What this block does
// RQ1 - Analog local loop ignores receive line inputs
// RQ2 - Analog loop drives line and feeds receive
// RQ3 - Host: local one, remote zero gives analog
// RQ4 - Hardware: local pin high, remote low: analog
// RQ5 - Digital loop routes transmit data to receive
// RQ6 - Host: both loop bits one gives digital
// RQ7 - Hardware: both loop pins high gives digital
// RQ8 - Remote loop retransmits received data, ignores rails
// RQ9 - Host: remote one, local zero gives remote
// RQ10 - Hardware: remote pin high, local low: remote
// RQ11 - Shut-off disables transmitter, tri-states both outputs
// RQ12 - Hardware shut-off pin controls all channels together
// RQ13 - Host: shut-off bit one off, zero on
// RQ14 - Shut-off pin acts directly, faster than writes
// RQ15 - Transmitter on only when pin and bit low; hardware mode ignores the bit
// RQ16 - All register fields reset to zero
// RQ17 - Both selects zero gives normal operation

`define CHAN_STRIDE     5'h08
`define TX_CTRL_OFS     5'h01
`define LOOP_CFG_OFS    5'h04
`define SHUTOFF_BIT     4
`define LOCAL_LOOP_BIT  1
`define REMOTE_LOOP_BIT 0
`define REG_RESET       5'h00
`define REG_WIDTH       5
`define ADDR_WIDTH      5
`define CHANNELS        3
`define BUF_DEPTH       2
`endif

// >>> loopback_pkg.sv
package loopback_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_ANALOG_LOCAL,
    MODE_DIGITAL_LOCAL,
    MODE_REMOTE
  } loop_mode_e;

  typedef struct packed {
    logic [1:0] hw_sync;
    logic [4:0] read_data;
  } top_s;

  typedef struct packed {
    logic [1:0] tx_clock_in_sync;
    logic       tx_clock_in_prev;
    logic [1:0] txp_sync;
    logic [1:0] txn_sync;
    logic [1:0] rx_recovered_clock_sync;
    logic       rx_recovered_clock_prev;
    logic [1:0] rxp_sync;
    logic [1:0] rxn_sync;
    logic [1:0] llb_sync;
    logic [1:0] rlb_sync;
    logic [1:0] stall_sync;
    logic [4:0] tx_ctrl;
    logic [4:0] loop_cfg;
    logic       tx_pos;
    logic       tx_neg;
    logic       rx_pos;
    logic       rx_neg;
    logic       rx_clk;
  } chan_s;

endpackage : loopback_pkg

// >>> rail_buffer.sv
`timescale 1ns/10ps
module rail_buffer #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  input wire logic     clk,
  input wire logic     rstn,
  rail_buffer_if.store bus
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } buf_s;

  buf_s st;
  buf_s next_st;
  logic push;
  logic pop;

  assign bus.in_ready  = (st.count != CW'(DEPTH));
  assign bus.out_valid = (st.count != '0);
  assign bus.out_data  = st.mem[st.rd_ptr];
  assign push          = bus.in_valid && bus.in_ready;
  assign pop           = bus.out_valid && bus.out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr] = bus.in_data;
      next_st.wr_ptr = (st.wr_ptr == PW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == PW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   next_st.count = st.count + 1'b1;
      2'b01:   next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : rail_buffer

// >>> rail_buffer_if.sv
`timescale 1ns/10ps
interface rail_buffer_if #(
  parameter int WIDTH = 2
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport store (
    input  in_valid,
    input  in_data,
    output in_ready,
    output out_valid,
    output out_data,
    input  out_ready
  );

  modport user (
    output in_valid,
    output in_data,
    input  in_ready,
    input  out_valid,
    input  out_data,
    output out_ready
  );
endinterface : rail_buffer_if

// >>> tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin \
  checked++; \
  if ((a) !== (e)) begin \
    err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
  end \
end
`define WT(s, e) begin \
  for (w = 0; w < 300 && (s) !== (e); w++) #10; \
  `CHK(s, e) \
  if (w == 300) end_of_test(); \
end
module tb_top;
  logic       clk;
  logic       rstn;
  logic       hw_mode;
  logic       shut;
  logic       we;
  logic       run;
  logic [1:0] md;
  logic [4:0] addr, wd, rdat;
  logic [2:0] loc, rem, tck, tp, tn, lck, lp, ln;
  logic [2:0] txp, txn, oe_n, rxp, rxn, rxc, stall, rdy;
  int         checked = 0;
  int         err_total = 0;
  int         w;

  framer_model #(.PH(0)) i_tx (.run(run), .pat(2'b10), .ck(tck), .p(tp),
    .n(tn));
  framer_model #(.PH(31)) i_line (.run(run), .pat(2'b01), .ck(lck), .p(lp),
    .n(ln));

  loopback_ctrl i_dut (
    .clk(clk), .rstn(rstn), .hardware_mode(hw_mode),
    .transmit_shutoff(shut), .local_loop_select(loc),
    .remote_loop_select(rem), .reg_addr(addr), .reg_wdata(wd),
    .reg_write(we), .reg_rdata(rdat), .tx_clock_in(tck),
    .tx_pos_rail_in(tp), .tx_neg_rail_in(tn), .tx_line_pos(txp),
    .tx_line_neg(txn), .tx_line_oe_n(oe_n), .rx_line_clock(lck),
    .rx_line_pos(lp), .rx_line_neg(ln), .rx_pos_rail_out(rxp),
    .rx_neg_rail_out(rxn), .rx_recovered_clock(rxc), .rx_stall(stall),
    .rx_ready(rdy));

  task automatic wr(input logic [4:0] a, input logic [4:0] d);
    addr = a;
    wd   = d;
    we   = 1'b1;
    #10;
    we = 1'b0;
    #10;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [4:0] e);
    addr = a;
    #20;
    `CHK(rdat, e)
  endtask : rd

  task automatic end_of_test();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rstn, hw_mode, shut, loc, rem, addr, wd, we, stall, run} = '0;
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    run  = 1'b1;
    for (int c = 0; c < 3; c++) begin
      rd(5'(8 * c + 1), 5'h00);
      rd(5'(8 * c + 4), 5'h00);
    end
    wr(5'h0c, 5'h1f);
    rd(5'h0c, 5'h1f);
    wr(5'h05, 5'h1f);
    rd(5'h05, 5'h00);
    `CHK(oe_n, 3'h0)
    // Host then pin control, other source set to the opposite mode
    for (int m = 0; m < 8; m++) begin
      md      = m[1:0];
      hw_mode = m[2];
      loc     = {3{md[1] ^ !m[2]}};
      rem     = {3{md[0] ^ !m[2]}};
      for (int c = 0; c < 3; c++) wr(5'(8 * c + 4), {3'h0, md ^ {2{m[2]}}});
      `WT(rxp, {3{md[1]}})
      `WT(rxn, {3{!md[1]}})
      `WT(txp, {3{md != 2'h1}})
      `WT(txn, {3{md == 2'h1}})
      `WT(rxc, 3'h7)
      `WT(rxc, 3'h0)
    end
    shut = 1'b1;
    #5;
    `CHK(oe_n, 3'h7)
    #5;
    `WT(txp, 3'h0)
    wr(5'h09, 5'h10);
    shut = 1'b0;
    #10;
    `CHK(oe_n, 3'h0)
    hw_mode = 1'b0;
    `WT(oe_n, 3'h2)
    rd(5'h09, 5'h10);
    wr(5'h09, 5'h10);
    `CHK(oe_n, 3'h2)
    wr(5'h09, 5'h00);
    `CHK(oe_n, 3'h0)
    stall = 3'h7;
    `WT(rdy, 3'h0)
    stall = 3'h0;
    `WT(rdy, 3'h7)
    wr(5'h0c, 5'h1f);
    rstn = 1'b0;
    #20;
    `CHK(oe_n, 3'h7)
    rstn = 1'b1;
    rd(5'h0c, 5'h00);
    run = 1'b0;
    end_of_test();
  end
endmodule : tb_top
